/* File: hdl/rtc_cal.sv */
// rtc offset calibration and temperature compensation unit
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module rtc_cal #(
  parameter int QS_PULSES = rtc_cal_pkg::RTC_QS_PULSES
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire rtc_cal_pkg::rtc_bus_req_t bus,
  output logic [15:0] rdata,
  // 32768 hz oscillator pin
  input wire logic lf_clk_in,
  // calibration test output pin
  output logic cal_test_output,
  output logic cal_test_output_oe,
  // event pulses to the interrupt flag logic
  output logic first_prescaler_flag,
  output logic second_prescaler_flag,
  output logic interval_event_flag
);
  import rtc_cal_pkg::*;

  // whole state of the unit
  typedef struct packed {
    logic [1:0] lf_sync;
    logic lf_prev;
    logic q0_tog;
    logic counter_hold;
    rtc_fsel_t cal_out_freq_sel;
    logic [2:0] first_prescaler_irq_interval;
    logic [2:0] rt1_interval;
    logic [7:0] offset_cal_magnitude;
    logic offset_cal_sign;
    logic [7:0] temp_comp_magnitude;
    logic temp_comp_sign;
    logic sign_pend;
    logic [7:0] xfer_mag;
    logic xfer_sign;
    logic [1:0] xfer_cnt;
    logic temp_comp_write_ready;
    logic temp_comp_write_ok;
    logic [11:0] qs_cnt;
    logic [7:0] quarter;
    logic [7:0] remain;
    logic dir_up;
    logic ins_pend;
    logic rem_pend;
    logic [14:0] pre;
    logic [5:0] sec;
    logic cal_out;
    logic cal_oe;
    logic f0;
    logic f1;
    logic fev;
    logic [15:0] rdata;
  } rtc_state_t;

  rtc_state_t q; // registered state
  rtc_state_t next_q; // next state
  logic lf_tick; // one cycle per oscillator rising edge
  logic run; // counters running
  logic q0_pulse; // uncorrected 16k pulse
  logic off_tick; // oscillator edge between 16k pulses
  logic corr; // corrected 16k pulse
  logic signed [9:0] sum; // signed offset plus compensation
  logic signed [9:0] eff; // clamped correction
  logic [8:0] sum_mag; // magnitude of the sum
  logic [7:0] sched; // corrections left before scheduling

  // sign and magnitude to signed value, sign set means speed up
  function automatic logic signed [9:0] rtc_signed(input logic s, input logic [7:0] m);
    logic signed [9:0] v;
    v = signed'({2'b00, m});
    return s ? v : -v;
  endfunction

  // true when every bit of v up to index k is one (carry out of that stage)
  function automatic logic rtc_carry(input logic [14:0] v, input logic [3:0] k);
    logic r;
    r = 1'b1;
    for (int i = 0; i < 15; i++) begin
      if (i <= int'(k)) begin
        r = r & v[i];
      end
    end
    return r;
  endfunction

  // correction sum and its limit
  always_comb begin
    sum = rtc_signed(q.offset_cal_sign, q.offset_cal_magnitude)
        + rtc_signed(q.temp_comp_sign, q.temp_comp_magnitude);
    sum_mag = sum[9] ? 9'(-sum) : sum[8:0];
    // excess beyond the limit is simply dropped
    if (sum > RTC_LIMIT) begin
      eff = RTC_LIMIT;
    end else if (sum < -RTC_LIMIT) begin
      eff = -RTC_LIMIT;
    end else begin
      eff = sum;
    end
  end

  // next state
  always_comb begin
    next_q = q;
    // two-flop synchroniser, edge taken from the second flop only
    next_q.lf_sync = {q.lf_sync[0], lf_clk_in};
    next_q.lf_prev = q.lf_sync[1];
    lf_tick = q.lf_sync[1] & ~q.lf_prev;
    run = ~q.counter_hold;
    q0_pulse = run & lf_tick & q.q0_tog;
    off_tick = run & lf_tick & ~q.q0_tog;
    // removal swallows a 16k pulse, insertion fills the gap between two
    corr = (q0_pulse & ~q.rem_pend) | (off_tick & q.ins_pend);
    sched = q.remain;
    if (run & lf_tick) begin
      next_q.q0_tog = ~q.q0_tog;
    end
    if (q0_pulse) begin
      next_q.rem_pend = 1'b0;
    end
    if (off_tick) begin
      next_q.ins_pend = 1'b0;
    end
    if (corr) begin
      next_q.pre = q.pre + 15'h0001;
    end
    // quarter second timer on the uncorrected clock
    if (q0_pulse) begin
      if (q.qs_cnt == 12'(QS_PULSES - 1)) begin
        next_q.qs_cnt = 12'h000;
        if (q.quarter == RTC_LAST_QUARTER) begin
          // new sixty second cycle: latch the limited sum
          next_q.quarter = 8'h00;
          sched = eff[9] ? 8'(-eff) : eff[7:0];
          next_q.dir_up = ~eff[9];
        end else begin
          next_q.quarter = q.quarter + 8'h01;
        end
        // one correction at most per quarter second
        if (sched != 8'h00) begin
          next_q.remain = sched - 8'h01;
          next_q.ins_pend = (sched != 8'h00) & ((q.quarter == RTC_LAST_QUARTER)
                            ? ~eff[9] : q.dir_up);
          next_q.rem_pend = (sched != 8'h00) & ((q.quarter == RTC_LAST_QUARTER)
                            ? eff[9] : ~q.dir_up);
        end else begin
          next_q.remain = 8'h00;
        end
      end else begin
        next_q.qs_cnt = q.qs_cnt + 12'h001;
      end
    end
    // held counters apply nothing and drop any pending correction
    if (q.counter_hold) begin
      next_q.ins_pend = 1'b0;
      next_q.rem_pend = 1'b0;
    end
    // event taps from the corrected prescaler, except the first tap at interval 000, which uses the uncorrected 16k pulse
    next_q.f0 = (q.first_prescaler_irq_interval == 3'b000) ? q0_pulse
              : corr & rtc_carry(q.pre, 4'(q.first_prescaler_irq_interval - 3'h1));
    next_q.f1 = corr & rtc_carry(q.pre, RTC_TAP_RT1 + 4'(q.rt1_interval));
    next_q.fev = 1'b0;
    if (corr & rtc_carry(q.pre, RTC_TAP_1HZ)) begin
      if (q.sec == RTC_LAST_SEC) begin
        next_q.sec = 6'h00;
        next_q.fev = 1'b1;
      end else begin
        next_q.sec = q.sec + 6'h01;
      end
    end
    // test output taken from the corrected prescaler
    case (q.cal_out_freq_sel)
      RTC_F512: next_q.cal_out = q.pre[RTC_TAP_512];
      RTC_F256: next_q.cal_out = q.pre[RTC_TAP_256];
      RTC_F1HZ: next_q.cal_out = q.pre[RTC_TAP_1HZ];
      default: next_q.cal_out = 1'b0;
    endcase
    next_q.cal_oe = (q.cal_out_freq_sel != RTC_FOFF);
    // compensation transfer completes on oscillator edges
    if (lf_tick & (q.xfer_cnt != 2'h0)) begin
      next_q.xfer_cnt = q.xfer_cnt - 2'h1;
      if (q.xfer_cnt == 2'h1) begin
        next_q.temp_comp_magnitude = q.xfer_mag;
        next_q.temp_comp_sign = q.xfer_sign;
        next_q.temp_comp_write_ready = 1'b1;
      end
    end
    // register writes, no unlock needed anywhere
    if (bus.wr) begin
      if (bus.addr == RTC_CTRL_OFS) begin
        next_q.counter_hold = bus.wdata[RTC_HOLD_BIT];
        next_q.cal_out_freq_sel = rtc_fsel_t'(bus.wdata[RTC_FSEL_LSB +: 2]);
        next_q.first_prescaler_irq_interval = bus.wdata[RTC_IP0_LSB +: 3];
        next_q.rt1_interval = bus.wdata[RTC_IP1_LSB +: 3];
      end else if (bus.addr == RTC_OCAL_OFS) begin
        // software is expected to hold the clock here; not enforced
        next_q.offset_cal_magnitude = bus.wdata[7:0];
        next_q.offset_cal_sign = bus.wdata[RTC_SIGN_BIT];
        next_q.temp_comp_magnitude = 8'h00;
        next_q.temp_comp_sign = 1'b0;
        next_q.xfer_cnt = 2'h0;
        next_q.temp_comp_write_ready = 1'b1;
      end else if (bus.addr == RTC_TCMP_HI_OFS) begin
        next_q.sign_pend = bus.wdata[RTC_SIGN_BIT];
      end else if (bus.addr == RTC_TCMP_LO_OFS) begin
        if (q.temp_comp_write_ready) begin
          next_q.xfer_mag = bus.wdata[7:0];
          next_q.xfer_sign = q.sign_pend;
          next_q.xfer_cnt = RTC_XFER_TICKS;
          next_q.temp_comp_write_ready = 1'b0;
          next_q.temp_comp_write_ok = 1'b1;
        end else begin
          next_q.temp_comp_write_ok = 1'b0;
        end
      end
    end
    // read data stands only in the cycle after the strobe
    next_q.rdata = RTC_ZERO16;
    if (bus.rd) begin
      if (bus.addr == RTC_CTRL_OFS) begin
        next_q.rdata = {5'h00, q.rt1_interval, 1'b0, q.first_prescaler_irq_interval,
                        q.cal_out_freq_sel, q.counter_hold};
      end else if (bus.addr == RTC_OCAL_OFS) begin
        next_q.rdata = {q.offset_cal_sign, 7'h00, q.offset_cal_magnitude};
      end else if (bus.addr == RTC_TCMP_LO_OFS || bus.addr == RTC_TCMP_HI_OFS) begin
        next_q.rdata = {~sum[9], q.temp_comp_write_ready, q.temp_comp_write_ok,
                        4'h0, sum_mag};
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.counter_hold <= RTC_HOLD_RST;
      q.temp_comp_write_ready <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from flops
  assign rdata = q.rdata;
  assign cal_test_output = q.cal_out;
  assign cal_test_output_oe = q.cal_oe;
  assign first_prescaler_flag = q.f0;
  assign second_prescaler_flag = q.f1;
  assign interval_event_flag = q.fev;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // pin released whenever select is off
  pin_release_a: assert property (q.cal_out_freq_sel == RTC_FOFF |=> !cal_test_output_oe)
    else $error("test output driven with select off");
  // readback of offset
  ocal_readback_a: assert property (bus.wr && bus.addr == RTC_OCAL_OFS ##1 !bus.wr && bus.rd
      && bus.addr == RTC_OCAL_OFS |=> rdata[7:0] == $past(bus.wdata[7:0], 2))
    else $error("offset readback differs from write");
  // no corrections while held
  hold_blocks_a: assert property (q.counter_hold |=> !q.ins_pend && !q.rem_pend)
    else $error("correction pending while held");
  // offset write clears compensation
  ocal_clears_a: assert property (bus.wr && bus.addr == RTC_OCAL_OFS
      |=> q.temp_comp_magnitude == 8'h00 && q.xfer_cnt == 2'h0)
    else $error("compensation survives offset write");
  // correction never both directions
  single_dir_a: assert property (!(q.ins_pend && q.rem_pend))
    else $error("insert and remove pending together");
  // sum limit
  sum_clamp_a: assert property (eff <= RTC_LIMIT && eff >= -RTC_LIMIT)
    else $error("correction beyond limit");
  // raw tap when interval is zero
  raw_tap_a: assert property (q.first_prescaler_irq_interval == 3'b000 && q0_pulse
      && $stable(q.first_prescaler_irq_interval) |=> first_prescaler_flag)
    else $error("uncorrected tap missed");
  // rejected write clears ok
  reject_ok_a: assert property (bus.wr && bus.addr == RTC_TCMP_LO_OFS
      && !q.temp_comp_write_ready |=> !q.temp_comp_write_ok && (q.xfer_cnt == $past(q.xfer_cnt)
      || q.xfer_cnt == $past(q.xfer_cnt) - 2'h1))
    else $error("rejected write not reported");
  // accepted write drops ready
  accept_busy_a: assert property (bus.wr && bus.addr == RTC_TCMP_LO_OFS
      && q.temp_comp_write_ready |=> q.temp_comp_write_ok && !q.temp_comp_write_ready)
    else $error("ready still set during transfer");
  // read data only after a strobe
  rdata_idle_a: assert property (!bus.rd |=> rdata == RTC_ZERO16)
    else $error("read data outside read cycle");

  ins_seen_c: cover property (off_tick && q.ins_pend);
  rem_seen_c: cover property (q0_pulse && q.rem_pend);
  xfer_done_c: cover property (q.xfer_cnt == 2'h1 && lf_tick);
  minute_c: cover property (interval_event_flag);
endmodule

/* File: hdl/rtc_cal_pkg.sv */
// package: constants, register map and types of the rtc frequency correction unit
//
// Overview of operation
// - select 00 leaves test output undriven
// - offset magnitude eight bits, limit 240
// - offset register reads back last write
// - no offset correction when held or zero
// - offset write clears temperature compensation
// - sixty second cycles, one 16k pulse/ppm
// - positive inserts pulse, negative removes pulse
// - offset sign set speeds up, clear slows
// - at most one correction per quarter second
// - test output taken from corrected clock
// - interval 000 uncorrected, others corrected clock
// - second prescaler, interval flags use corrected clock
// - compensation: low magnitude, high byte sign
// - compensation register needs no unlock
// - no compensation when held or zero
// - compensation takes effect next cycle only
// - signed sum clamped to plus/minus 240
// - compensation read returns signed sum
// - sign byte alone stays pending
// - ready bit; writes while not ready dropped
// - ok bit reports last write outcome
// - value applied once per minute, persists
package rtc_cal_pkg;
  // register byte offsets
  localparam logic [7:0] RTC_CTRL_OFS = 8'h00;
  localparam logic [7:0] RTC_OCAL_OFS = 8'h04;
  localparam logic [7:0] RTC_TCMP_LO_OFS = 8'h08;
  localparam logic [7:0] RTC_TCMP_HI_OFS = 8'h0C;
  // control register fields
  localparam int RTC_HOLD_BIT = 0;
  localparam int RTC_FSEL_LSB = 1;
  localparam int RTC_IP0_LSB = 4;
  localparam int RTC_IP1_LSB = 8;
  // calibration register fields
  localparam int RTC_SIGN_BIT = 15;
  localparam int RTC_RDY_BIT = 14;
  localparam int RTC_OK_BIT = 13;
  // reset values
  localparam logic RTC_HOLD_RST = 1'b1;
  localparam logic [15:0] RTC_ZERO16 = 16'h0000;
  // timing: cycle length, quarter seconds, pulses per quarter
  localparam int RTC_CYCLE_S = 60;
  localparam int RTC_Q0_HZ = 16384;
  localparam int RTC_QUARTERS = RTC_CYCLE_S * 4;
  localparam int RTC_QS_PULSES = RTC_Q0_HZ / 4;
  localparam logic [7:0] RTC_LAST_QUARTER = 8'(RTC_QUARTERS - 1);
  localparam logic [1:0] RTC_XFER_TICKS = 2'h2;
  // correction limit in ppm
  localparam logic signed [9:0] RTC_LIMIT = 10'sd240;
  // prescaler tap indices (bit j runs at 16384 / 2^(j+1) Hz)
  localparam logic [3:0] RTC_TAP_512 = 4'h4;
  localparam logic [3:0] RTC_TAP_256 = 4'h5;
  localparam logic [3:0] RTC_TAP_1HZ = 4'hD;
  localparam logic [3:0] RTC_TAP_RT1 = 4'h7;
  localparam logic [5:0] RTC_LAST_SEC = 6'(RTC_CYCLE_S - 1);

  // output frequency select codes
  typedef enum logic [1:0] {
    RTC_FOFF = 2'b00,
    RTC_F512 = 2'b01,
    RTC_F256 = 2'b10,
    RTC_F1HZ = 2'b11
  } rtc_fsel_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rtc_bus_req_t;
endpackage

/* File: testbench/tb_rtc_cal.sv */
// self-checking bench for the rtc frequency correction unit
`timescale 1ns/100ps
module tb_rtc_cal;
  import rtc_cal_pkg::*;
  // clock, reset and pins
  logic clk;
  logic arst_n;
  logic lf_clk_in;
  rtc_bus_req_t bus;
  logic [15:0] rdata;
  logic cal_test_output;
  logic cal_test_output_oe;
  logic first_prescaler_flag;
  logic second_prescaler_flag;
  logic interval_event_flag;
  // bookkeeping
  int failures = 0;
  int checked = 0;
  int lf_ticks = 0;
  int ticks;
  int flags;
  logic [15:0] rd_val;

  // short quarter second keeps each correction window small
  localparam int QS = 4;
  rtc_cal #(.QS_PULSES(QS)) dut (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
    .lf_clk_in(lf_clk_in), .cal_test_output(cal_test_output),
    .cal_test_output_oe(cal_test_output_oe), .first_prescaler_flag(first_prescaler_flag),
    .second_prescaler_flag(second_prescaler_flag), .interval_event_flag(interval_event_flag));

  // 40 mhz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // sped-up oscillator: ppm figures are ratios, so only run time changes
  initial begin
    lf_clk_in = 1'b0;
    #37;
    forever #100 lf_clk_in = ~lf_clk_in;
  end
  // oscillator tick count, the time base of every rate check
  always @(posedge lf_clk_in) begin
    lf_ticks <= lf_ticks + 1;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic logic [15:0] inr(input int v, input int lo, input int hi);
    return (v >= lo && v <= hi) ? 16'h0001 : 16'h0000;
  endfunction

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    v = rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    rd(a, rd_val);
    chk(rd_val, exp);
  endtask

  // polls the ready bit; a transfer that never ends is a failure
  task automatic wait_ready();
    int n;
    n = 0;
    rd(RTC_TCMP_LO_OFS, rd_val);
    while (rd_val[RTC_RDY_BIT] !== 1'b1) begin
      n++;
      if (n > 200) begin
        failures++;
        give_verdict();
      end
      rd(RTC_TCMP_LO_OFS, rd_val);
    end
  endtask

  task automatic do_reset();
    arst_n <= 1'b0;
    bus <= '0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
  endtask

  // oscillator ticks across n test output edges, raw-rate flags meanwhile
  task automatic meas(input int n);
    int e;
    int c;
    int t0;
    logic prev;
    e = 0;
    c = 0;
    t0 = 0;
    flags = 0;
    @(posedge clk);
    #1;
    prev = cal_test_output;
    while (e <= n && c < 40000) begin
      @(posedge clk);
      #1;
      c++;
      if (e > 0 && first_prescaler_flag === 1'b1) begin
        flags++;
      end
      if (cal_test_output !== prev) begin
        if (e == 0) begin
          t0 = lf_ticks;
        end
        e++;
      end
      prev = cal_test_output;
    end
    ticks = lf_ticks - t0;
    if (c >= 40000) begin
      failures++;
      give_verdict();
    end
  endtask

  // fresh start, offset written while held, then run with raw first interval
  // settle waits out the first cycle, since the sum is latched at its end only
  task automatic run(input logic [15:0] ofs, input logic [1:0] fsel, input int n,
                     input bit settle);
    int t;
    int i;
    do_reset();
    wr(RTC_OCAL_OFS, ofs);
    wr(RTC_CTRL_OFS, {13'h0000, fsel, 1'b0});
    t = lf_ticks;
    i = 0;
    while (settle && lf_ticks < t + RTC_QUARTERS * QS * 2 - 20 && i < 20000) begin
      @(posedge clk);
      i++;
    end
    if (i >= 20000) begin
      failures++;
      give_verdict();
    end
    meas(n);
  endtask

  // main sequence
  initial begin
    arst_n = 1'b0;
    bus = '0;
    do_reset();
    @(posedge clk);
    #1;
    chk({15'h0000, cal_test_output_oe}, 16'h0000);
    rchk(RTC_TCMP_LO_OFS, 16'hC000);
    // offset readback, then read data falls back
    wr(RTC_OCAL_OFS, 16'h8042);
    rchk(RTC_OCAL_OFS, 16'h8042);
    @(posedge clk);
    #1;
    chk(rdata, 16'h0000);
    // -16 against +66: ready drops during the transfer
    wr(RTC_TCMP_LO_OFS, 16'h0010);
    rchk(RTC_TCMP_LO_OFS, 16'hA042);
    wait_ready();
    chk(rd_val, 16'hE032);
    rchk(RTC_OCAL_OFS, 16'h8042);
    // back-to-back: second write meets ready low and is dropped
    @(posedge clk);
    bus <= '{addr: RTC_TCMP_LO_OFS, wdata: 16'h0020, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: RTC_TCMP_LO_OFS, wdata: 16'h0030, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    wait_ready();
    chk(rd_val, 16'hC022);
    // sign byte alone stays pending
    wr(RTC_TCMP_HI_OFS, 16'h8000);
    rd(RTC_TCMP_LO_OFS, rd_val);
    chk(rd_val & 16'hC1FF, 16'hC022);
    wr(RTC_TCMP_LO_OFS, 16'h0010);
    wait_ready();
    chk(rd_val, 16'hE052);
    // offset write clears compensation; sum read is unclamped
    wr(RTC_OCAL_OFS, 16'h8096);
    rd(RTC_TCMP_LO_OFS, rd_val);
    chk(rd_val & 16'hC1FF, 16'hC096);
    wr(RTC_TCMP_HI_OFS, 16'h8000);
    wr(RTC_TCMP_LO_OFS, 16'h00C8);
    wait_ready();
    chk(rd_val, 16'hE15E);
    wr(RTC_OCAL_OFS, 16'h0005);
    rd(RTC_TCMP_LO_OFS, rd_val);
    chk(rd_val & 16'hC1FF, 16'h4005);
    // unmapped place: write ignored, reads zero
    wr(8'h10, 16'hFFFF);
    rchk(8'h10, 16'h0000);
    rchk(RTC_OCAL_OFS, 16'h0005);
    // nominal rates with zero offset
    run(16'h0000, RTC_F512, 10, 1'b0);
    chk(16'(ticks), 16'h0140);
    chk({15'h0000, cal_test_output_oe}, 16'h0001);
    run(16'h0000, RTC_F256, 4, 1'b0);
    chk(16'(ticks), 16'h0100);
    wr(RTC_CTRL_OFS, {13'h0000, RTC_F1HZ, 1'b0});
    repeat (3) @(posedge clk);
    #1;
    chk({15'h0000, cal_test_output_oe}, 16'h0001);
    // up, down and heavy correction seen on the test output
    run(16'h800A, RTC_F512, 10, 1'b1);
    chk(inr(ticks, 292, 318), 16'h0001);
    chk(inr(flags, ticks / 2 - 2, ticks / 2 + 2), 16'h0001);
    run(16'h000A, RTC_F512, 10, 1'b1);
    chk(inr(ticks, 324, 344), 16'h0001);
    chk(inr(flags, ticks / 2 - 2, ticks / 2 + 2), 16'h0001);
    run(16'h80C8, RTC_F512, 10, 1'b1);
    chk(inr(ticks, 248, 272), 16'h0001);
    give_verdict();
  end
endmodule
